// ===== core/utopia_l2_map.vh
// constants for the utopia level 2 phy-side cell port
// Functional notes
// - address 00h selects first line port
// - direct tx avail high while port accepts
// - tx enable plus start marker begins cell
// - tx avail drops without room for cell
// - direct rx avail high with full cell
// - first byte and marker after rx enable
// - rx start marker only on first byte
// - rx avail drops without full cell
// - tx polled avail answers next clock; the input synchronisers make it the third clock from the pins
// - polls answered during ongoing transfer
// - rx polled avail answers next clock; the input synchronisers make it the third clock from the pins
// - deselected port three-states its outputs
// - no next cell means no marker
// - enable dropped means outputs off next clock; the input synchronisers make it the third clock from the pins
// - resumed cell continues at the next unsent byte
// - in-band address mark input ignored
// - packet abort input ignored in cell mode
// - active-low reset clears all logic async except the cell store contents
`ifndef UTOPIA_L2_MAP_VH
`define UTOPIA_L2_MAP_VH
`define NUM_PORTS     4
`define PORT_BITS     2
`define ADDR_BITS     5
`define CELL_BYTES    53
`define BYTE_CNT_BITS 6
`define LAST_BYTE     6'h34
`define FIRST_PORT    5'h00
`endif

// ===== core/cell_buffer.v
// one-cell store for a single port, tx or rx side
`timescale 1ns/100ps
`default_nettype none
`include "utopia_l2_map.vh"
module cell_buffer (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  // write side
  input  wire       wr_i,
  input  wire [5:0] wr_idx_i,
  input  wire [7:0] wr_data_i,
  input  wire       wr_done_i,
  // read side
  input  wire [5:0] rd_idx_i,
  input  wire       rd_done_i,
  output wire [7:0] rd_data_o,
  output reg        full_o
);
  reg [7:0] mem [0:`CELL_BYTES-1];

  assign rd_data_o = mem[rd_idx_i];

  always @(posedge clk_sys_i) begin
    if (wr_i)
      mem[wr_idx_i] <= wr_data_i;
  end

  // a finished write wins over a same-cycle drain so no cell is lost
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      full_o <= 1'b0;
    else if (wr_done_i)
      full_o <= 1'b1;
    else if (rd_done_i)
      full_o <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== core/utopia_l2_phy_cell_port.v
// phy-side utopia level 2 cell port for four line ports
`timescale 1ns/100ps
`default_nettype none
`include "utopia_l2_map.vh"
module utopia_l2_phy_cell_port (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  // transmit cell bus from controller
  input  wire [4:0]  tx_port_select_i,
  input  wire        tx_enable_n_i,
  input  wire        tx_start_of_cell_i,
  input  wire [7:0]  tx_data_i,
  input  wire        tx_inband_addr_mark_i,
  input  wire        tx_packet_abort_i,
  input  wire        tx_end_of_packet_i,
  output reg  [3:0]  tx_port_cell_avail_o,
  output reg         tx_polled_avail_o,
  // receive cell bus to controller
  input  wire [4:0]  rx_port_select_i,
  input  wire        rx_enable_n_i,
  output reg  [7:0]  rx_cell_bus_alt_o,
  output reg         rx_start_of_cell_o,
  output wire        rx_out_en_n_o,
  output reg  [3:0]  rx_port_cell_avail_o,
  output reg         rx_polled_avail_o,
  // line side: cells out of the tx stores
  input  wire [3:0]  line_tx_take_i,
  output wire [3:0]  line_tx_full_o,
  // line side: cells into the rx stores
  input  wire [3:0]  line_rx_wr_i,
  input  wire [5:0]  line_rx_idx_i,
  input  wire [7:0]  line_rx_data_i,
  input  wire [3:0]  line_rx_done_i,
  output wire [3:0]  line_rx_full_o,
  // line side: read port of tx stores
  input  wire [5:0]  line_tx_idx_i,
  output wire [31:0] line_tx_data_o
);
  // inputs come from the controller's clock domain: two flops each
  reg [4:0] tx_port_select_s1, tx_port_select;
  reg       ten_s1, ten_n;
  reg       tsoc_s1, tsoc;
  reg [7:0] tdat_s1, tdat;
  reg [4:0] rx_port_select_s1, rx_port_select;
  reg       ren_s1, ren_n;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_port_select_s1 <= 5'h00;
      tx_port_select    <= 5'h00;
      ten_s1  <= 1'b1;
      ten_n   <= 1'b1;
      tsoc_s1 <= 1'b0;
      tsoc    <= 1'b0;
      tdat_s1 <= 8'h00;
      tdat    <= 8'h00;
      rx_port_select_s1 <= 5'h00;
      rx_port_select    <= 5'h00;
      ren_s1  <= 1'b1;
      ren_n   <= 1'b1;
    end else begin
      tx_port_select_s1 <= tx_port_select_i;
      tx_port_select    <= tx_port_select_s1;
      ten_s1  <= tx_enable_n_i;
      ten_n   <= ten_s1;
      tsoc_s1 <= tx_start_of_cell_i;
      tsoc    <= tsoc_s1;
      tdat_s1 <= tx_data_i;
      tdat    <= tdat_s1;
      rx_port_select_s1 <= rx_port_select_i;
      rx_port_select    <= rx_port_select_s1;
      ren_s1  <= rx_enable_n_i;
      ren_n   <= ren_s1;
    end
  end

  // in-band address mark, packet abort and end of packet have no use in cell mode
  wire unused_in = tx_inband_addr_mark_i ^ tx_packet_abort_i ^ tx_end_of_packet_i;

  // address 00h is the first port; addresses past the ports match nothing
  function [4:0] port_hit;
    input [4:0] adr;
    reg   [4:0] off;
    begin
      off      = adr - `FIRST_PORT;
      port_hit = 5'h00;
      if (off < `NUM_PORTS)
        port_hit = {1'b1, 2'h0, off[1:0]};
    end
  endfunction

  // one-hot mask of a port; used for busy masks and store drains
  function [3:0] one_hot;
    input [1:0] p;
    begin
      one_hot = 4'h1 << p;
    end
  endfunction

  // last byte of a cell, counted from the byte that carried the marker
  function cell_end;
    input [5:0] cnt;
    begin
      cell_end = (cnt == `LAST_BYTE);
    end
  endfunction

  wire [4:0] t_hit = port_hit(tx_port_select);
  wire [4:0] r_hit = port_hit(rx_port_select);

  // ---------------- transmit side ----------------
  localparam TX_IDLE = 1'b0;
  localparam TX_CELL = 1'b1;

  reg        tx_state;
  reg        next_tx_state;
  reg [1:0]  tx_sel;
  reg [1:0]  tx_port;
  reg        tx_sel_ok;
  reg [5:0]  tx_cnt;
  wire [3:0] tx_full;
  wire       tx_act = (tx_state == TX_CELL);

  wire tx_first = !ten_n && tsoc && tx_sel_ok && !tx_full[tx_sel];
  wire tx_more  = !ten_n && tx_act && !tsoc;
  wire tx_wr    = tx_first || tx_more;
  wire [5:0] tx_idx = tx_first ? 6'h00 : tx_cnt;
  wire tx_last  = tx_more && cell_end(tx_cnt);

  // a marker mid-cell restarts the cell; the store is marked full only at the end
  always @* begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE:
        if (tx_first)
          next_tx_state = TX_CELL;
      TX_CELL:
        if (tx_last)
          next_tx_state = TX_IDLE;
      default:
        next_tx_state = TX_IDLE;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state  <= TX_IDLE;
      tx_sel    <= 2'h0;
      tx_sel_ok <= 1'b0;
      tx_port   <= 2'h0;
      tx_cnt    <= 6'h00;
    end else begin
      tx_state <= next_tx_state;
      // address is latched while enable is high; taken on the falling enable
      if (ten_n) begin
        tx_sel    <= t_hit[1:0];
        tx_sel_ok <= t_hit[4];
      end
      if (tx_first) begin
        tx_port <= tx_sel;
        tx_cnt  <= 6'h01;
      end else if (tx_more) begin
        tx_cnt <= tx_cnt + 6'h01;
      end
    end
  end

  // ---------------- receive side ----------------
  reg        rx_act;
  reg        rx_drv;
  reg [1:0]  rx_sel;
  reg        rx_sel_ok;
  reg [1:0]  rx_port;
  reg [5:0]  rx_cnt;
  reg [3:0]  rx_pend;
  wire [3:0] rx_full;
  wire [31:0] rx_rd_data;
  wire [1:0] rx_src = rx_act ? rx_port : rx_sel;
  wire [7:0] rx_byte = rx_rd_data[8*rx_src +: 8];

  // a cell may start only if the port holds it whole
  wire rx_can_start = rx_sel_ok && rx_full[rx_sel];
  wire rx_go        = !ren_n;

  // what the rx side does on the next edge
  localparam RX_OFF   = 2'h0;
  localparam RX_NEXT  = 2'h1;
  localparam RX_START = 2'h2;
  localparam RX_QUIET = 2'h3;

  reg [1:0] rx_step;

  // limitation: starting a cell on another port abandons a parked one,
  // which is then sent again from its first byte when that port is picked
  always @* begin
    rx_step = RX_QUIET;
    if (!rx_go)
      rx_step = RX_OFF;
    else if (rx_act && rx_port == rx_sel)
      rx_step = RX_NEXT;
    else if (rx_can_start)
      rx_step = RX_START;
  end

  // only a byte really sent from the owning port may close its cell
  wire       rx_end   = (rx_step == RX_NEXT) && cell_end(rx_cnt);
  wire [3:0] rx_drain = rx_end ? one_hot(rx_port) : 4'h0;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_act             <= 1'b0;
      rx_drv             <= 1'b0;
      rx_sel             <= 2'h0;
      rx_sel_ok          <= 1'b0;
      rx_port            <= 2'h0;
      rx_cnt             <= 6'h00;
      rx_pend            <= 4'h0;
      rx_cell_bus_alt_o  <= 8'h00;
      rx_start_of_cell_o <= 1'b0;
    end else begin
      if (ren_n) begin
        rx_sel    <= r_hit[1:0];
        rx_sel_ok <= r_hit[4];
      end
      rx_start_of_cell_o <= 1'b0;
      case (rx_step)
        RX_OFF: begin
          // enable dropped: float next clock even mid-cell
          rx_drv <= 1'b0;
        end
        RX_NEXT: begin
          // continuing, or resuming after deselect at the next byte
          rx_drv            <= 1'b1;
          rx_cell_bus_alt_o <= rx_byte;
          rx_cnt            <= rx_cnt + 6'h01;
          if (rx_end)
            rx_act <= 1'b0;
        end
        RX_START: begin
          // first byte with marker, marker gone on the next clock
          rx_act             <= 1'b1;
          rx_drv             <= 1'b1;
          rx_port            <= rx_sel;
          rx_cnt             <= 6'h01;
          rx_cell_bus_alt_o  <= rx_byte;
          rx_start_of_cell_o <= 1'b1;
        end
        default: begin
          // held enable with nothing to send: stay quiet, no marker
          rx_drv <= 1'b0;
        end
      endcase
      rx_pend <= rx_drain;
    end
  end

  // outputs float while nothing is sent; low enable means the pins are driven
  assign rx_out_en_n_o = ~rx_drv;

  // ---------------- availability flags ----------------
  // the port in transfer is never offered for a second cell: one store each
  reg [3:0] tx_room;
  reg [3:0] rx_ready;

  always @* begin
    tx_room  = ~tx_full;
    rx_ready = rx_full & ~rx_pend;
    if (tx_act)
      tx_room = tx_room & ~one_hot(tx_port);
    if (rx_act)
      rx_ready = rx_ready & ~one_hot(rx_port);
  end

  // avail follows store state, with the port in transfer masked off
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_port_cell_avail_o <= 4'h0;
      rx_port_cell_avail_o <= 4'h0;
      tx_polled_avail_o    <= 1'b0;
      rx_polled_avail_o    <= 1'b0;
    end else begin
      tx_port_cell_avail_o <= tx_room;
      rx_port_cell_avail_o <= rx_ready;
      tx_polled_avail_o    <= t_hit[4] && tx_room[t_hit[1:0]];
      rx_polled_avail_o    <= r_hit[4] && rx_ready[r_hit[1:0]];
    end
  end

  // ---------------- one-cell stores per port ----------------
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g = g + 1) begin : port
      cell_buffer u_tx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (tx_wr && ((tx_first ? tx_sel : tx_port) == g)),
        .wr_idx_i  (tx_idx),
        .wr_data_i (tdat),
        .wr_done_i (tx_last && tx_port == g),
        .rd_idx_i  (line_tx_idx_i),
        .rd_done_i (line_tx_take_i[g]),
        .rd_data_o (line_tx_data_o[8*g +: 8]),
        .full_o    (tx_full[g])
      );
      cell_buffer u_rx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (line_rx_wr_i[g]),
        .wr_idx_i  (line_rx_idx_i),
        .wr_data_i (line_rx_data_i),
        .wr_done_i (line_rx_done_i[g]),
        .rd_idx_i  (rx_act && rx_port == g ? rx_cnt : 6'h00),
        .rd_done_i (rx_drain[g]),
        .rd_data_o (rx_rd_data[8*g +: 8]),
        .full_o    (rx_full[g])
      );
    end
  endgenerate

  assign line_tx_full_o = tx_full;
  assign line_rx_full_o = rx_full;
endmodule
`default_nettype wire

// ===== testbench/utopia_l2_phy_cell_port_checker.sv
// assertions on the cell port pins
`timescale 1ns/100ps
`default_nettype none
module utopia_l2_phy_cell_port_checker (
  // clock and reset
  input wire       clk_sys_i,
  input wire       rst_n_i,
  // watched pins
  input wire [4:0] tx_port_select_i,
  input wire [4:0] rx_port_select_i,
  input wire       rx_enable_n_i,
  input wire       rx_start_of_cell_o,
  input wire       rx_out_en_n_o,
  input wire [3:0] rx_port_cell_avail_o,
  input wire       rx_polled_avail_o,
  input wire [3:0] tx_port_cell_avail_o,
  input wire       tx_polled_avail_o,
  input wire [3:0] line_tx_full_o,
  input wire [3:0] line_rx_full_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // answers trail the pins by three clocks through the input synchronisers
  sequence s_held; !rx_enable_n_i [*4]; endsequence
  sequence s_first; rx_start_of_cell_o && !rx_out_en_n_o; endsequence
  property p_next; s_held ##0 s_first |=> !rx_out_en_n_o && !rx_start_of_cell_o; endproperty
  property p_off; $rose(rx_enable_n_i) |-> ##[3:4] rx_out_en_n_o; endproperty
  property p_sof; $rose(rx_start_of_cell_o) |-> !$past(rx_enable_n_i, 3); endproperty
  property p_rnone; (rx_port_select_i > 5'h03) [*5] |-> !rx_polled_avail_o; endproperty
  property p_tnone; (tx_port_select_i > 5'h03) [*5] |-> !tx_polled_avail_o; endproperty
  property p_rpoll;
    (rx_port_select_i == 5'h01 && rx_port_cell_avail_o[1]) [*5] |-> rx_polled_avail_o;
  endproperty
  property p_tpoll;
    (tx_port_select_i == 5'h01 && tx_port_cell_avail_o[1]) [*5] |-> tx_polled_avail_o;
  endproperty
  property p_tfull; $rose(line_tx_full_o[0]) |-> ##[0:2] !tx_port_cell_avail_o[0]; endproperty
  property p_rfull; $rose(line_rx_full_o[1]) |-> ##[0:2] rx_port_cell_avail_o[1]; endproperty
  a_next: assert property (p_next) else $error("rx marker too long");
  a_off: assert property (p_off) else $error("rx bus still on");
  a_sof: assert property (p_sof) else $error("rx marker unasked");
  a_rnone: assert property (p_rnone) else $error("rx poll no port");
  a_tnone: assert property (p_tnone) else $error("tx poll no port");
  a_rpoll: assert property (p_rpoll) else $error("rx poll missed");
  a_tpoll: assert property (p_tpoll) else $error("tx poll missed");
  a_tfull: assert property (p_tfull) else $error("tx avail when full");
  a_rfull: assert property (p_rfull) else $error("rx avail missing");
endmodule
bind utopia_l2_phy_cell_port utopia_l2_phy_cell_port_checker chk_u (
  .clk_sys_i, .rst_n_i, .tx_port_select_i, .rx_port_select_i, .rx_enable_n_i,
  .rx_start_of_cell_o, .rx_out_en_n_o, .rx_port_cell_avail_o, .rx_polled_avail_o,
  .tx_port_cell_avail_o, .tx_polled_avail_o, .line_tx_full_o, .line_rx_full_o);
`default_nettype wire

// ===== testbench/atm_ctrl_model.sv
// controller model on the cell bus
`timescale 1ns/100ps
`default_nettype none
module atm_ctrl_model (
  // clock and receive pins
  input wire             clk_i,
  input wire [7:0]       dat_rx_i,
  input wire             sof_rx_i,
  input wire             oe_rx_n_i,
  // controller outputs
  output var logic [4:0] sel_tx_o,
  output var logic       en_tx_n_o,
  output var logic       sof_tx_o,
  output var logic [7:0] dat_tx_o,
  output var logic [4:0] sel_rx_o,
  output var logic       en_rx_n_o
);
  logic [8:0] got[$];
  initial begin
    sel_tx_o = 5'h1f;
    en_tx_n_o = 1'b1;
    sof_tx_o = 1'b0;
    dat_tx_o = 8'h00;
    sel_rx_o = 5'h1f;
    en_rx_n_o = 1'b1;
  end
  // only bytes the device really drives are taken
  always @(posedge clk_i)
    if (!oe_rx_n_i)
      got.push_back({sof_rx_i, dat_rx_i});
  task automatic poll(input logic [4:0] t, input logic [4:0] r);
    @(posedge clk_i) #1 sel_tx_o = t;
    sel_rx_o = r;
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  task automatic send_cell(input logic [4:0] p, input logic [7:0] s, input logic [4:0] q);
    @(posedge clk_i) #1 sel_tx_o = p;
    for (int i = 0; i < 53; i++) begin
      @(posedge clk_i) #1 en_tx_n_o = 1'b0;
      sof_tx_o = (i == 0);
      dat_tx_o = s + 8'(i);
      if (i == 2)
        sel_tx_o = q;
    end
    @(posedge clk_i) #1 en_tx_n_o = 1'b1;
    sof_tx_o = 1'b0;
    // released data flips so a stale byte cannot pass for a live one
    dat_tx_o = ~dat_tx_o;
  endtask
  task automatic rx_run(input logic [4:0] p, input int n);
    @(posedge clk_i) #1 sel_rx_o = p;
    @(posedge clk_i) #1 en_rx_n_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1 en_rx_n_o = 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== testbench/utopia_l2_phy_cell_port_bench.sv
// self-checking bench for the cell port
`timescale 1ns/100ps
`default_nettype none
`define CHK(w, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", w, e, s); end end
module utopia_l2_phy_cell_port_bench;
  logic        clk_sys_i, rst_n_i, tx_enable_n_i, tx_start_of_cell_i, rx_enable_n_i;
  logic        tx_inband_addr_mark_i, tx_packet_abort_i, tx_end_of_packet_i;
  logic        tx_polled_avail_o, rx_start_of_cell_o, rx_out_en_n_o, rx_polled_avail_o;
  logic [4:0]  tx_port_select_i, rx_port_select_i;
  logic [7:0]  tx_data_i, rx_cell_bus_alt_o, line_rx_data_i;
  logic [3:0]  tx_port_cell_avail_o, rx_port_cell_avail_o, line_tx_take_i, line_tx_full_o;
  logic [3:0]  line_rx_wr_i, line_rx_done_i, line_rx_full_o;
  logic [5:0]  line_rx_idx_i, line_tx_idx_i;
  logic [31:0] line_tx_data_o;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  utopia_l2_phy_cell_port dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .tx_port_select_i(tx_port_select_i), .tx_enable_n_i(tx_enable_n_i),
    .tx_start_of_cell_i(tx_start_of_cell_i), .tx_data_i(tx_data_i),
    .tx_inband_addr_mark_i(tx_inband_addr_mark_i), .tx_packet_abort_i(tx_packet_abort_i),
    .tx_end_of_packet_i(tx_end_of_packet_i), .tx_port_cell_avail_o(tx_port_cell_avail_o),
    .tx_polled_avail_o(tx_polled_avail_o), .rx_port_select_i(rx_port_select_i),
    .rx_enable_n_i(rx_enable_n_i), .rx_cell_bus_alt_o(rx_cell_bus_alt_o),
    .rx_start_of_cell_o(rx_start_of_cell_o), .rx_out_en_n_o(rx_out_en_n_o),
    .rx_port_cell_avail_o(rx_port_cell_avail_o), .rx_polled_avail_o(rx_polled_avail_o),
    .line_tx_take_i(line_tx_take_i), .line_tx_full_o(line_tx_full_o),
    .line_rx_wr_i(line_rx_wr_i), .line_rx_idx_i(line_rx_idx_i),
    .line_rx_data_i(line_rx_data_i), .line_rx_done_i(line_rx_done_i),
    .line_rx_full_o(line_rx_full_o), .line_tx_idx_i(line_tx_idx_i),
    .line_tx_data_o(line_tx_data_o));
  atm_ctrl_model ctl_u (.clk_i(clk_sys_i), .dat_rx_i(rx_cell_bus_alt_o),
    .sof_rx_i(rx_start_of_cell_o), .oe_rx_n_i(rx_out_en_n_o), .sel_tx_o(tx_port_select_i),
    .en_tx_n_o(tx_enable_n_i), .sof_tx_o(tx_start_of_cell_i), .dat_tx_o(tx_data_i),
    .sel_rx_o(rx_port_select_i), .en_rx_n_o(rx_enable_n_i));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic fill(input int g, input logic [7:0] s);
    for (int i = 0; i < 53; i++) begin
      @(posedge clk_sys_i) #1 line_rx_wr_i = 4'h1 << g;
      line_rx_idx_i = 6'(i);
      line_rx_data_i = s + 8'(i);
    end
    @(posedge clk_sys_i) #1 line_rx_wr_i = 4'h0;
    line_rx_done_i = 4'h1 << g;
    @(posedge clk_sys_i) #1 line_rx_done_i = 4'h0;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk_cell(input logic [7:0] s);
    `CHK("rx count", 53, ctl_u.got.size())
    foreach (ctl_u.got[i]) `CHK("rx byte", ({i == 0, s + 8'(i)}), ctl_u.got[i])
    ctl_u.got.delete();
  endtask
  task automatic t_tx;
    `CHK("tx avail", 4'hf, tx_port_cell_avail_o)
    tx_inband_addr_mark_i = 1'b1;
    tx_packet_abort_i = 1'b1;
    ctl_u.send_cell(5'h00, 8'h10, 5'h01);
    tx_inband_addr_mark_i = 1'b0;
    tx_packet_abort_i = 1'b0;
    ctl_u.poll(5'h00, 5'h1f);
    `CHK("tx full", 4'h1, line_tx_full_o)
    `CHK("tx avail", 4'he, tx_port_cell_avail_o)
    `CHK("tx poll", 1'b0, tx_polled_avail_o)
    `CHK("tx first", 8'h10, line_tx_data_o[7:0])
    line_tx_idx_i = 6'h34;
    @(posedge clk_sys_i) #1 `CHK("tx last", 8'h44, line_tx_data_o[7:0])
    ctl_u.poll(5'h01, 5'h1f);
    `CHK("tx poll", 1'b1, tx_polled_avail_o)
    line_tx_take_i = 4'h1;
    @(posedge clk_sys_i) #1 line_tx_take_i = 4'h0;
    ctl_u.poll(5'h1f, 5'h1f);
    `CHK("tx avail", 4'hf, tx_port_cell_avail_o)
  endtask
  task automatic t_rx;
    fill(1, 8'h40);
    `CHK("rx full", 4'h2, line_rx_full_o)
    `CHK("rx avail", 4'h2, rx_port_cell_avail_o)
    ctl_u.poll(5'h1f, 5'h01);
    `CHK("rx poll", 1'b1, rx_polled_avail_o)
    ctl_u.poll(5'h1f, 5'h02);
    `CHK("rx poll", 1'b0, rx_polled_avail_o)
    ctl_u.rx_run(5'h01, 60);
    chk_cell(8'h40);
    `CHK("rx avail", 4'h0, rx_port_cell_avail_o)
    `CHK("rx off", 1'b1, rx_out_en_n_o)
  endtask
  task automatic t_resume;
    fill(2, 8'h80);
    ctl_u.rx_run(5'h02, 4);
    ctl_u.rx_run(5'h03, 8);
    ctl_u.rx_run(5'h02, 60);
    chk_cell(8'h80);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // a hung handshake ends the run here
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n_i = 1'b0;
    {tx_inband_addr_mark_i, tx_packet_abort_i, tx_end_of_packet_i} = 3'h0;
    {line_tx_take_i, line_rx_wr_i, line_rx_done_i} = 12'h000;
    {line_rx_idx_i, line_tx_idx_i, line_rx_data_i} = 20'h00000;
    repeat (16) @(posedge clk_sys_i);
    `CHK("reset avail", 4'h0, tx_port_cell_avail_o)
    `CHK("reset off", 1'b1, rx_out_en_n_o)
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 t_tx();
    $display("tx test done");
    t_rx();
    $display("rx test done");
    t_resume();
    $display("resume test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
